// [design/jtbs_defines.vh]
// Constants of the boundary-scan test access port: tap states, instruction
// codes, register widths, boundary cell positions and the software register map.
// Shared by the design and the verification files; holds definitions and nothing else.
//
// How it works
// - Only the four pins clock, mode, data in, data out reach the port.
// - Instruction register is sixteen bits; eight codes select data registers.
// - Code 0000 drives every pin but the external clock pin and observes all through the boundary register.
// - Code 0002 selects boundary register to observe and preload, pins untouched.
// - Code 0004 selects the identification register.
// - Code FFFF selects the one-bit bypass register.
// - Code 0082 selects the flash control register.
// - Code 0083 selects the flash data register for byte reads and writes.
// - A chosen flash address code selects the flash address register.
// - Three scan data registers plus four flash access registers exist.
// - Boundary register is 134 cells covering pins, pullup and bus.
// - External test captures and updates; sample captures and preloads, never drives.
// - Cells 0 and 1, then 2 and 3, hold reset enable and level.
// - Cell 4 captures the external clock pin; its update is unused.
// - Cell 5 captures the pullup enable and updates the pins' pullup.
// - Port bits pair from cell 6: even enable, odd data, to cell 133.
// - During external test every input to internal logic reads one.
// - Identification is version, part, maker, then a fixed one in bit 0.
// - Flash commands are twenty bits: two-bit operation over eighteen data bits.
`ifndef JTBS_DEFINES_VH
`define JTBS_DEFINES_VH

// Tap controller states
`define JTBS_ST_RESET     4'h0
`define JTBS_ST_IDLE      4'h1
`define JTBS_ST_SEL_DR    4'h2
`define JTBS_ST_CAP_DR    4'h3
`define JTBS_ST_SHIFT_DR  4'h4
`define JTBS_ST_EXIT1_DR  4'h5
`define JTBS_ST_PAUSE_DR  4'h6
`define JTBS_ST_EXIT2_DR  4'h7
`define JTBS_ST_UPD_DR    4'h8
`define JTBS_ST_SEL_IR    4'h9
`define JTBS_ST_CAP_IR    4'hA
`define JTBS_ST_SHIFT_IR  4'hB
`define JTBS_ST_EXIT1_IR  4'hC
`define JTBS_ST_PAUSE_IR  4'hD
`define JTBS_ST_EXIT2_IR  4'hE
`define JTBS_ST_UPD_IR    4'hF

// Instruction codes
`define JTBS_IR_W          16
`define JTBS_IR_EXTEST     16'h0000
`define JTBS_IR_SAMPLE     16'h0002
`define JTBS_IR_IDCODE     16'h0004
`define JTBS_IR_BYPASS     16'hFFFF
`define JTBS_IR_FL_CTRL    16'h0082
`define JTBS_IR_FL_BYTE    16'h0083
`define JTBS_IR_FL_ADDR    16'h0084
`define JTBS_IR_FL_SCALE   16'h0085
`define JTBS_IR_CAPTURE    16'h0001

// Data register geometry
`define JTBS_BSR_W         134
`define JTBS_ID_W          32
`define JTBS_FL_W          20
`define JTBS_FL_DATA_W     18
`define JTBS_FL_OP_HI      19
`define JTBS_FL_OP_LO      18

// Boundary cell positions
`define JTBS_CELL_RST_A_EN 0
`define JTBS_CELL_RST_A    1
`define JTBS_CELL_RST_B_EN 2
`define JTBS_CELL_RST_B    3
`define JTBS_CELL_XCLK     4
`define JTBS_CELL_PULLUP   5
`define JTBS_CELL_PORT0    6

// Flash register selectors on the request port
`define JTBS_FSEL_CTRL     2'h0
`define JTBS_FSEL_BYTE     2'h1
`define JTBS_FSEL_ADDR     2'h2
`define JTBS_FSEL_SCALE    2'h3

// Software register map (byte addresses)
`define JTBS_REG_CTRL      12'h000
`define JTBS_REG_STATUS    12'h004
`define JTBS_CTRL_RESET    32'h0000_0001

`endif

// [design/jtbs_tap.v]
// Boundary-scan test access port with boundary, identification, bypass and
// flash access data registers, plus a small APB register file.
// Assumes test pins arrive asynchronously and that pclk is several times faster
// than the test clock, which is sampled and edge-detected on pclk.
`timescale 1ns/1ps
`include "jtbs_defines.vh"

module jtbs_tap #(
    parameter NUM_PORT_BITS = 64,
    parameter [3:0] ID_VERSION = 4'h0, // Identification defaults are arbitrary values
    parameter [15:0] ID_PART = 16'h0ABC,
    parameter [10:0] ID_MAKER = 11'h155
) (
    // System clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Test pins
    input wire tck,
    input wire tms,
    input wire tdi,
    output reg tdo,
    output reg tdo_oe,
    // Pins of the device
    input wire [NUM_PORT_BITS-1:0] port_pin_in,
    output reg [NUM_PORT_BITS-1:0] port_pin_out,
    output reg [NUM_PORT_BITS-1:0] port_pin_oe,
    input wire [1:0] rst_pin_in,
    output reg [1:0] rst_pin_out,
    output reg [1:0] rst_pin_oe,
    input wire ext_clock_pin,
    output reg pullup_en,
    // Internal logic side
    input wire [NUM_PORT_BITS-1:0] core_port_out,
    input wire [NUM_PORT_BITS-1:0] core_port_oe,
    output reg [NUM_PORT_BITS-1:0] core_port_in,
    input wire [1:0] core_rst_out,
    input wire [1:0] core_rst_oe,
    output reg [1:0] core_rst_in,
    input wire core_pullup_en,
    // Flash access engine
    output reg flash_req,
    output reg flash_write,
    output reg [1:0] flash_sel,
    output reg [17:0] flash_wdata,
    input wire [17:0] flash_rdata,
    input wire flash_busy
);

localparam BW = `JTBS_BSR_W;
localparam SYNC_W = NUM_PORT_BITS + 6;
localparam [31:0] CTRL_RST = `JTBS_CTRL_RESET;

////////////////////////////////////////////////////////////////////////////////
// Synchronisers: three stages, a change counts once stages two and three agree

reg [SYNC_W-1:0] sync1;
reg [SYNC_W-1:0] sync2;
reg [SYNC_W-1:0] sync3;
reg [SYNC_W-1:0] pins_q;
reg tck_prev;
wire [SYNC_W-1:0] raw_pins;
wire [SYNC_W-1:0] agree;
wire tck_q;
wire tms_q;
wire tdi_q;
wire tck_rise;
wire tck_fall;
wire [NUM_PORT_BITS-1:0] port_q;

assign raw_pins = {port_pin_in, rst_pin_in, ext_clock_pin, tdi, tms, tck};
assign agree = ~(sync2 ^ sync3);

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        sync1 <= {SYNC_W{1'b0}};
        sync2 <= {SYNC_W{1'b0}};
        sync3 <= {SYNC_W{1'b0}};
        pins_q <= {SYNC_W{1'b0}};
        tck_prev <= 1'b0;
    end
    else
    begin
        sync1 <= raw_pins;
        sync2 <= sync1;
        sync3 <= sync2;
        pins_q <= (pins_q & ~agree) | (sync3 & agree);
        tck_prev <= pins_q[0];
    end
end

assign tck_q = pins_q[0];
assign tms_q = pins_q[1];
assign tdi_q = pins_q[2];
assign port_q = pins_q[SYNC_W-1:6];
assign tck_rise = tck_q & ~tck_prev;
assign tck_fall = ~tck_q & tck_prev;

////////////////////////////////////////////////////////////////////////////////
// Tap controller

reg [3:0] state;
reg [3:0] next_state;

always @*
begin
    case (state)
        `JTBS_ST_RESET: next_state = tms_q ? `JTBS_ST_RESET : `JTBS_ST_IDLE;
        `JTBS_ST_IDLE: next_state = tms_q ? `JTBS_ST_SEL_DR : `JTBS_ST_IDLE;
        `JTBS_ST_SEL_DR: next_state = tms_q ? `JTBS_ST_SEL_IR : `JTBS_ST_CAP_DR;
        `JTBS_ST_CAP_DR: next_state = tms_q ? `JTBS_ST_EXIT1_DR : `JTBS_ST_SHIFT_DR;
        `JTBS_ST_SHIFT_DR: next_state = tms_q ? `JTBS_ST_EXIT1_DR : `JTBS_ST_SHIFT_DR;
        `JTBS_ST_EXIT1_DR: next_state = tms_q ? `JTBS_ST_UPD_DR : `JTBS_ST_PAUSE_DR;
        `JTBS_ST_PAUSE_DR: next_state = tms_q ? `JTBS_ST_EXIT2_DR : `JTBS_ST_PAUSE_DR;
        `JTBS_ST_EXIT2_DR: next_state = tms_q ? `JTBS_ST_UPD_DR : `JTBS_ST_SHIFT_DR;
        `JTBS_ST_UPD_DR: next_state = tms_q ? `JTBS_ST_SEL_DR : `JTBS_ST_IDLE;
        `JTBS_ST_SEL_IR: next_state = tms_q ? `JTBS_ST_RESET : `JTBS_ST_CAP_IR;
        `JTBS_ST_CAP_IR: next_state = tms_q ? `JTBS_ST_EXIT1_IR : `JTBS_ST_SHIFT_IR;
        `JTBS_ST_SHIFT_IR: next_state = tms_q ? `JTBS_ST_EXIT1_IR : `JTBS_ST_SHIFT_IR;
        `JTBS_ST_EXIT1_IR: next_state = tms_q ? `JTBS_ST_UPD_IR : `JTBS_ST_PAUSE_IR;
        `JTBS_ST_PAUSE_IR: next_state = tms_q ? `JTBS_ST_EXIT2_IR : `JTBS_ST_PAUSE_IR;
        `JTBS_ST_EXIT2_IR: next_state = tms_q ? `JTBS_ST_UPD_IR : `JTBS_ST_SHIFT_IR;
        `JTBS_ST_UPD_IR: next_state = tms_q ? `JTBS_ST_SEL_DR : `JTBS_ST_IDLE;
        default: next_state = `JTBS_ST_RESET;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// Instruction decode

reg [15:0] ir;
reg [15:0] ir_sr;
reg ctrl_flash_en;
wire sel_bsr;
wire sel_id;
wire sel_flash;
wire extest;
reg [1:0] fsel;

assign extest = (ir == `JTBS_IR_EXTEST);
assign sel_bsr = extest | (ir == `JTBS_IR_SAMPLE);
assign sel_id = (ir == `JTBS_IR_IDCODE);
assign sel_flash = (ir == `JTBS_IR_FL_CTRL) | (ir == `JTBS_IR_FL_BYTE) |
                   (ir == `JTBS_IR_FL_ADDR) | (ir == `JTBS_IR_FL_SCALE);

always @*
begin
    case (ir)
        `JTBS_IR_FL_CTRL: fsel = `JTBS_FSEL_CTRL;
        `JTBS_IR_FL_BYTE: fsel = `JTBS_FSEL_BYTE;
        `JTBS_IR_FL_ADDR: fsel = `JTBS_FSEL_ADDR;
        default: fsel = `JTBS_FSEL_SCALE;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// Boundary capture vector and pin mapping

wire [BW-1:0] bcap;
reg [BW-1:0] bsr;
reg [BW-1:0] bupd;
reg [31:0] id_sr;
reg [19:0] fl_sr;
reg byp_sr;

assign bcap[`JTBS_CELL_RST_A_EN] = core_rst_oe[0];
assign bcap[`JTBS_CELL_RST_A] = pins_q[4];
assign bcap[`JTBS_CELL_RST_B_EN] = core_rst_oe[1];
assign bcap[`JTBS_CELL_RST_B] = pins_q[5];
assign bcap[`JTBS_CELL_XCLK] = pins_q[3];
assign bcap[`JTBS_CELL_PULLUP] = core_pullup_en;

genvar gi;
generate
    for (gi = 0; gi < NUM_PORT_BITS; gi = gi + 1)
    begin : g_cell
        assign bcap[`JTBS_CELL_PORT0 + 2*gi] = core_port_oe[gi];
        assign bcap[`JTBS_CELL_PORT0 + 2*gi + 1] = port_q[gi];
        always @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                port_pin_oe[gi] <= 1'b0;
                port_pin_out[gi] <= 1'b0;
                core_port_in[gi] <= 1'b0;
            end
            else if (extest)
            begin
                port_pin_oe[gi] <= bupd[`JTBS_CELL_PORT0 + 2*gi];
                port_pin_out[gi] <= bupd[`JTBS_CELL_PORT0 + 2*gi + 1];
                core_port_in[gi] <= 1'b1;
            end
            else
            begin
                port_pin_oe[gi] <= core_port_oe[gi];
                port_pin_out[gi] <= core_port_out[gi];
                core_port_in[gi] <= port_q[gi];
            end
        end
    end
endgenerate

// Cell 4 only observes, so its update latch drives nothing
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        rst_pin_oe <= 2'b00;
        rst_pin_out <= 2'b00;
        core_rst_in <= 2'b00;
        pullup_en <= 1'b0;
    end
    else if (extest)
    begin
        rst_pin_oe <= {bupd[`JTBS_CELL_RST_B_EN], bupd[`JTBS_CELL_RST_A_EN]};
        rst_pin_out <= {bupd[`JTBS_CELL_RST_B], bupd[`JTBS_CELL_RST_A]};
        core_rst_in <= 2'b11;
        pullup_en <= bupd[`JTBS_CELL_PULLUP];
    end
    else
    begin
        rst_pin_oe <= core_rst_oe;
        rst_pin_out <= core_rst_out;
        core_rst_in <= pins_q[5:4];
        pullup_en <= core_pullup_en;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Shift paths, capture and update

wire fl_launch;
wire [31:0] id_word;

assign id_word = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
// Poll never launches; read and write are dropped while the engine is busy
assign fl_launch = fl_sr[`JTBS_FL_OP_HI] & ~flash_busy & ctrl_flash_en;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        state <= `JTBS_ST_RESET;
        ir <= `JTBS_IR_IDCODE;
        ir_sr <= 16'h0000;
        bsr <= {BW{1'b0}};
        bupd <= {BW{1'b0}};
        id_sr <= 32'h0000_0000;
        fl_sr <= 20'h0_0000;
        byp_sr <= 1'b0;
        tdo <= 1'b0;
        tdo_oe <= 1'b0;
        flash_req <= 1'b0;
        flash_write <= 1'b0;
        flash_sel <= 2'b00;
        flash_wdata <= 18'h0_0000;
    end
    else
    begin
        flash_req <= 1'b0;
        if (tck_rise)
        begin
            state <= next_state;
            case (state)
                `JTBS_ST_RESET:
                begin
                    ir <= `JTBS_IR_IDCODE;
                    bupd <= {BW{1'b0}};
                end
                `JTBS_ST_CAP_IR: ir_sr <= `JTBS_IR_CAPTURE;
                `JTBS_ST_SHIFT_IR: ir_sr <= {tdi_q, ir_sr[15:1]};
                `JTBS_ST_CAP_DR:
                begin
                    bsr <= bcap;
                    id_sr <= id_word;
                    byp_sr <= 1'b0;
                    fl_sr <= {1'b0, flash_rdata, flash_busy};
                end
                `JTBS_ST_SHIFT_DR:
                begin
                    if (sel_bsr)
                        bsr <= {tdi_q, bsr[BW-1:1]};
                    else if (sel_id)
                        id_sr <= {tdi_q, id_sr[31:1]};
                    else if (sel_flash)
                        fl_sr <= {tdi_q, fl_sr[19:1]};
                    else
                        byp_sr <= tdi_q;
                end
                default:
                begin
                end
            endcase
        end
        if (tck_fall)
        begin
            tdo_oe <= (state == `JTBS_ST_SHIFT_DR) | (state == `JTBS_ST_SHIFT_IR);
            if (state == `JTBS_ST_SHIFT_IR)
                tdo <= ir_sr[0];
            else if (sel_bsr)
                tdo <= bsr[0];
            else if (sel_id)
                tdo <= id_sr[0];
            else if (sel_flash)
                tdo <= fl_sr[0];
            else
                tdo <= byp_sr;
            if (state == `JTBS_ST_UPD_IR)
                ir <= ir_sr;
            if (state == `JTBS_ST_UPD_DR && sel_bsr)
                bupd <= bsr;
            if (state == `JTBS_ST_UPD_DR && sel_flash && fl_launch)
            begin
                flash_req <= 1'b1;
                flash_write <= fl_sr[`JTBS_FL_OP_LO];
                flash_sel <= fsel;
                flash_wdata <= fl_sr[17:0];
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// APB register file; zero wait states

wire apb_wr;
wire mapped;

assign pready = 1'b1;
assign mapped = (paddr == `JTBS_REG_CTRL) | (paddr == `JTBS_REG_STATUS);
assign pslverr = psel & penable & ~mapped;
assign apb_wr = psel & penable & pwrite & (paddr == `JTBS_REG_CTRL);

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        ctrl_flash_en <= CTRL_RST[0];
    else if (apb_wr)
        ctrl_flash_en <= pwdata[0];
end

// Read data is registered in the setup cycle so it stands through the access phase
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        prdata <= 32'h0000_0000;
    else if (psel & ~penable)
    begin
        case (paddr)
            `JTBS_REG_CTRL: prdata <= {31'h0000_0000, ctrl_flash_en};
            `JTBS_REG_STATUS: prdata <= {ir, 10'h000, extest, flash_busy, state};
            default: prdata <= 32'h0000_0000;
        endcase
    end
end

endmodule

// [sim/jtbs_chk_checker.sv]
// Port-level checker for the test access port.
// Assumes the bench never drives all port pins high outside external test.
`timescale 1ns/1ps
`include "jtbs_defines.vh"
module jtbs_chk #(parameter NUM_PORT_BITS = 64) (
    // Clock, reset and bus
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic [11:0] paddr,
    input logic pready,
    input logic pslverr,
    // Pins and core side
    input logic [NUM_PORT_BITS-1:0] port_pin_out,
    input logic [NUM_PORT_BITS-1:0] port_pin_oe,
    input logic [NUM_PORT_BITS-1:0] core_port_out,
    input logic [NUM_PORT_BITS-1:0] core_port_oe,
    input logic [NUM_PORT_BITS-1:0] core_port_in,
    input logic [1:0] core_rst_in,
    input logic pullup_en,
    input logic core_pullup_en,
    // Flash requests
    input logic flash_req,
    input logic [17:0] flash_wdata
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // All-ones core inputs only happen under external test
    wire ext = &core_port_in;
    wire mapped = paddr == `JTBS_REG_CTRL || paddr == `JTBS_REG_STATUS;
    sequence s_norm;
        !ext && !$past(ext) && $past(presetn);
    endsequence
    sequence s_pulse;
        flash_req ##1 !flash_req;
    endsequence
    property p_pin;
        s_norm |-> port_pin_out == $past(core_port_out) && port_pin_oe == $past(core_port_oe);
    endproperty
    a_pin: assert property (p_pin) else $error("pins left the core");
    property p_pull;
        s_norm |-> pullup_en == $past(core_pullup_en);
    endproperty
    a_pull: assert property (p_pull) else $error("pullup left the core");
    property p_ones;
        ext && $past(ext) |-> &core_rst_in;
    endproperty
    a_ones: assert property (p_ones) else $error("core reset input not one");
    property p_pulse;
        $rose(flash_req) |-> s_pulse;
    endproperty
    a_pulse: assert property (p_pulse) else $error("flash request too long");
    property p_hold;
        !flash_req |-> $stable(flash_wdata);
    endproperty
    a_hold: assert property (p_hold) else $error("flash data moved");
    property p_rdy;
        psel && penable |-> pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("bus not ready");
    property p_unm;
        psel && penable && !mapped |-> pslverr;
    endproperty
    a_unm: assert property (p_unm) else $error("unmapped access accepted");
    property p_map;
        pslverr |-> psel && penable && !mapped;
    endproperty
    a_map: assert property (p_map) else $error("spurious bus error");
endmodule
bind jtbs_tap jtbs_chk #(.NUM_PORT_BITS(NUM_PORT_BITS)) u_chk (.pclk, .presetn, .psel,
    .penable, .paddr, .pready, .pslverr, .port_pin_out, .port_pin_oe, .core_port_out,
    .core_port_oe, .core_port_in, .core_rst_in, .pullup_en, .core_pullup_en, .flash_req,
    .flash_wdata);

// [sim/jtbs_jtag_model.sv]
// Test controller model driving the test clock, mode and data pins.
// Assumes a 40 ns pclk; the test clock runs (8 pclk) only inside a scan or a tap reset.
`timescale 1ns/1ps
module jtbs_jtag_model (
    // System clock
    input logic pclk,
    // Test pins
    output logic tck,
    output logic tms,
    output logic tdi,
    input logic tdo
);
    initial {tck, tms, tdi} = 3'h2;
    // Low 4 pclk, high 4 pclk; tdo is stable long before the fall
    task automatic tick(input logic m, input logic d, output logic q);
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge pclk);
        tck <= 1'b1;
        repeat (4) @(posedge pclk);
        q = tdo;
        tck <= 1'b0;
    endtask
    // Don't-care data bits flip so a stale level is never trusted
    task automatic scan(input logic ir, input int n, input logic [133:0] din,
        output logic [133:0] dout);
        logic q;
        dout = '0;
        tick(1'b1, ~tdi, q);
        if (ir)
            tick(1'b1, ~tdi, q);
        tick(1'b0, ~tdi, q);
        tick(1'b0, ~tdi, q);
        for (int i = 0; i < n; i++)
        begin
            tick(i == n - 1, din[i], q);
            dout[i] = q;
        end
        tick(1'b1, ~tdi, q);
        tick(1'b0, ~tdi, q);
    endtask
    task automatic tap_reset();
        logic q;
        repeat (5) tick(1'b1, ~tdi, q);
        tick(1'b0, ~tdi, q);
    endtask
endmodule

// [sim/test_jtag_tap_boundary_scan.sv]
// Self-checking bench: scan chains, pins, flash requests and the APB registers.
// Assumes the controller model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`include "jtbs_defines.vh"
module test_jtag_tap_boundary_scan;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, tck, tms, tdi, tdo, tdo_oe, ext_clock_pin = 0, pullup_en;
    logic core_pullup_en = 0, flash_req, flash_write, flash_busy = 0;
    logic [63:0] port_pin_in = '0, port_pin_out, port_pin_oe;
    logic [63:0] core_port_out = '0, core_port_oe = '0, core_port_in;
    logic [1:0] rst_pin_in = '0, rst_pin_out, rst_pin_oe, core_rst_in, flash_sel;
    logic [1:0] core_rst_out = '0, core_rst_oe = '0;
    logic [17:0] flash_rdata = '0, flash_wdata;
    logic [133:0] v;
    int errors = 0, comparisons = 0, nreq = 0;
    localparam logic [31:0] ID = {4'h3, 16'h5A5A, 11'h2C1, 1'b1};
    localparam logic [133:0] P = {67{2'h2}};
    localparam logic [133:0] Q = {{64{2'h1}}, 6'h2B};
    // Identification values are arbitrary
    jtbs_tap #(.ID_VERSION(4'h3), .ID_PART(16'h5A5A), .ID_MAKER(11'h2C1)) dut (.pclk,
        .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .tck, .tms, .tdi, .tdo, .tdo_oe, .port_pin_in, .port_pin_out, .port_pin_oe,
        .rst_pin_in, .rst_pin_out, .rst_pin_oe, .ext_clock_pin, .pullup_en, .core_port_out,
        .core_port_oe, .core_port_in, .core_rst_out, .core_rst_oe, .core_rst_in,
        .core_pullup_en, .flash_req, .flash_write, .flash_sel, .flash_wdata, .flash_rdata,
        .flash_busy);
    // A released data-out pin reads inverted, so a sample outside a shift state is caught
    jtbs_jtag_model u_jtag (.pclk, .tck, .tms, .tdi, .tdo(tdo_oe ? tdo : ~tdo));
    always #20 pclk = ~pclk;
    always @(posedge pclk) if (flash_req === 1'b1) nreq <= nreq + 1;
    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string what, input logic [133:0] exp, input logic [133:0] got);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Ends one idle cycle after release so back-to-back calls never collide
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge pclk);
            i++;
        end
        while (pready !== 1'b1 && i < 16);
        if (pready !== 1'b1)
        begin
            errors++;
            stop_test();
        end
        {err, rd} = {pslverr, prdata};
        {psel, penable} <= 2'h0;
        @(posedge pclk);
    endtask
    task automatic ir(input logic [15:0] c);
        u_jtag.scan(1'b1, 16, c, v);
        chk("ir capture", `JTBS_IR_CAPTURE, v[15:0]);
    endtask
    function automatic logic [133:0] cap();
        logic [133:0] b;
        b[5:0] = {core_pullup_en, ext_clock_pin, rst_pin_in[1], core_rst_oe[1],
            rst_pin_in[0], core_rst_oe[0]};
        for (int i = 0; i < 64; i++) b[6 + 2 * i +: 2] = {port_pin_in[i], core_port_oe[i]};
        return b;
    endfunction
    function automatic logic [133:0] pins();
        logic [133:0] b;
        b[5:0] = {pullup_en, 1'b0, rst_pin_out[1], rst_pin_oe[1], rst_pin_out[0], rst_pin_oe[0]};
        for (int i = 0; i < 64; i++) b[6 + 2 * i +: 2] = {port_pin_out[i], port_pin_oe[i]};
        return b;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_id();
        u_jtag.tap_reset();
        u_jtag.scan(1'b0, 32, '0, v);
        chk("reset idcode", ID, v[31:0]);
        ir(`JTBS_IR_IDCODE);
        u_jtag.scan(1'b0, 32, '0, v);
        chk("idcode", ID, v[31:0]);
    endtask
    task automatic t_bypass();
        ir(`JTBS_IR_BYPASS);
        u_jtag.scan(1'b0, 3, 3'h5, v);
        chk("bypass", 3'h2, v[2:0]);
    endtask
    task automatic t_sample();
        port_pin_in <= 64'hA5C3_0F96_1234_5678;
        core_port_oe <= 64'h0FF0_3C3C_8001_7E7E;
        core_port_out <= 64'h1111_2222_4444_8888;
        {core_rst_out, rst_pin_in, core_rst_oe, ext_clock_pin, core_pullup_en} <= 8'h67;
        ir(`JTBS_IR_SAMPLE);
        u_jtag.scan(1'b0, 134, P, v);
        chk("sample capture", cap(), v);
        chk("sample pins", {core_port_out, core_port_oe, core_rst_out, core_rst_oe},
            {port_pin_out, port_pin_oe, rst_pin_out, rst_pin_oe});
        chk("sample core inputs", {rst_pin_in, port_pin_in, core_pullup_en},
            {core_rst_in, core_port_in, pullup_en});
    endtask
    task automatic t_extest();
        ir(`JTBS_IR_EXTEST);
        chk("preload pins", P, pins());
        chk("core inputs", {66{1'b1}}, {core_rst_in, core_port_in});
        u_jtag.scan(1'b0, 134, Q, v);
        chk("extest capture", cap(), v);
        chk("extest pins", Q, pins());
        u_jtag.tap_reset();
        chk("released pins", {core_port_out, core_port_oe}, {port_pin_out, port_pin_oe});
    endtask
    task automatic t_flash();
        logic [15:0] codes [4];
        int n;
        codes = '{`JTBS_IR_FL_CTRL, `JTBS_IR_FL_BYTE, `JTBS_IR_FL_ADDR, `JTBS_IR_FL_SCALE};
        flash_rdata <= 18'h2_B3C9;
        for (int k = 0; k < 4; k++)
        begin
            n = nreq;
            ir(codes[k]);
            u_jtag.scan(1'b0, 20, {2'h3, 16'h8000, k[1:0]}, v);
            chk("flash capture", {1'b0, 18'h2_B3C9, 1'b0}, v[19:0]);
            chk("flash write", {n + 1, 3'h4 + k[1:0], 16'h8000, k[1:0]},
                {nreq, flash_write, flash_sel, flash_wdata});
        end
        u_jtag.scan(1'b0, 20, 20'h8_0000, v);
        chk("flash read", {n + 2, 1'b0}, {nreq, flash_write});
        flash_busy <= 1'b1;
        u_jtag.scan(1'b0, 20, 20'hC_0001, v);
        chk("busy capture", 1'b1, v[0]);
        flash_busy <= 1'b0;
        u_jtag.scan(1'b0, 20, 20'h4_0002, v);
        chk("refused requests", n + 2, nreq);
    endtask
    task automatic t_apb();
        int n;
        apb(1'b0, `JTBS_REG_CTRL, '0);
        chk("ctrl reset", `JTBS_CTRL_RESET, {err, rd});
        apb(1'b1, `JTBS_REG_CTRL, '0);
        n = nreq;
        u_jtag.scan(1'b0, 20, 20'hC_0005, v);
        chk("disabled flash", n, nreq);
        apb(1'b1, `JTBS_REG_CTRL, `JTBS_CTRL_RESET);
        apb(1'b0, `JTBS_REG_STATUS, '0);
        chk("status", {1'b0, `JTBS_IR_FL_SCALE, 16'h0001}, {err, rd});
        apb(1'b1, 12'h008, 32'hFFFF_FFFF);
        chk("unmapped write", 1'b1, err);
        apb(1'b0, 12'h008, '0);
        chk("unmapped read", 33'h1_0000_0000, {err, rd});
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        t_id();
        t_bypass();
        t_sample();
        t_extest();
        t_flash();
        t_apb();
        stop_test();
    end
    initial
    begin
        repeat (40000) @(posedge pclk);
        errors++;
        stop_test();
    end
endmodule
